// *** hw/ppd_pkg.sv ***
package ppd_pkg;
  // Register access
  localparam int             DATA_W    = 24;
  localparam int             ADDR_W    = 6;
  localparam logic [5:0]     ADDR_PUMP = 6'h09;
  localparam logic [5:0]     ADDR_TRIG = 6'h0A;
  localparam logic [5:0]     ADDR_PD   = 6'h0B;
  localparam logic [23:0]    RD_ZERO   = 24'h000000;
  // Reset values
  localparam logic [23:0]    PUMP_RST  = 24'h40050A;
  localparam logic [23:0]    TRIG_RST  = 24'h002205;
  localparam logic [23:0]    TRIG_PROG = 24'h001800;
  localparam logic [23:0]    PD_RST    = 24'h0F8061;
  // Pump register fields
  localparam int             GAIN_W      = 7;
  localparam int             P_LGAIN_LSB = 0;
  localparam int             P_RGAIN_LSB = 7;
  localparam int             P_OFS_LSB   = 14;
  localparam int             P_OFS_UP    = 21;
  localparam int             P_OFS_DN    = 22;
  localparam int             P_HIGAIN    = 23;
  // Phase detector register fields
  localparam int             DLY_W       = 3;
  localparam int             PSB_W       = 3;
  localparam int             F2_W        = 2;
  localparam int             D_DLY_LSB   = 0;
  localparam int             D_TIE       = 3;
  localparam int             D_FLIP      = 4;
  localparam int             D_RAISE_EN  = 5;
  localparam int             D_LOWER_EN  = 6;
  localparam int             D_CSP_LSB   = 7;
  localparam int             D_FRC_RAISE = 9;
  localparam int             D_FRC_LOWER = 10;
  localparam int             D_FRC_MID   = 11;
  localparam int             D_PSB_LSB   = 12;
  localparam int             D_OPB_LSB   = 15;
  localparam int             D_MCG_LSB   = 17;
  localparam int             D_DPW_LSB   = 20;
  // Cycle-slip thresholds in ns, per mode code
  localparam logic [1:0]     CSP_OFF     = 2'h0;
  localparam logic [1:0]     CSP_M1      = 2'h1;
  localparam logic [1:0]     CSP_M2      = 2'h2;
  localparam logic [4:0]     CSP_NS_1    = 5'h06;
  localparam logic [4:0]     CSP_NS_2    = 5'h0E;
  localparam logic [4:0]     CSP_NS_3    = 5'h18;
  localparam logic [4:0]     CSP_NS_OFF  = 5'h00;
  // Main counter gating limits per code; zero means all clocks on
  localparam logic [1:0]     MCG_C0      = 2'h0;
  localparam logic [1:0]     MCG_C1      = 2'h1;
  localparam logic [1:0]     MCG_C2      = 2'h2;
  localparam logic [10:0]    MCG_LIM_0   = 11'h020;
  localparam logic [10:0]    MCG_LIM_1   = 11'h080;
  localparam logic [10:0]    MCG_LIM_2   = 11'h3FF;
  localparam logic [10:0]    MCG_LIM_ON  = 11'h000;
  localparam logic [6:0]     GAIN_ZERO   = 7'h00;
endpackage

// *** hw/ppd_reg24.sv ***
`timescale 1ns/10ps
// One read/write configuration word; every bit kept, including spares
module ppd_reg24 #(
  parameter int          W   = 24,
  parameter logic [23:0] RST = 24'h000000
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Write port
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  // Stored value
  output logic      [W-1:0] q
);
  // Synchronous reset to the documented default
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= RST[W-1:0];
    end else if (wr_en) begin
      q <= wdata;
    end
  end
endmodule // ppd_reg24

// *** hw/pump_phase_detector_regs.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Down pump gain, bits 6:0, default ten, one current step per count.
// - Up pump gain, bits 13:7, default ten, one current step per count.
// - Pump offset magnitude, bits 20:14, default zero.
// - Bit 21 applies offset upward; zero turns up offset off; default zero.
// - Bit 22 applies offset downward; zero turns down offset off; default one.
// - Bit 23 selects high-gain pump mode; needs the op-amp kept enabled.
// - Bits 2:0 pick detector reset-path delay, default one.
// - Bit 3 ties detector inputs together, test only, default zero.
// - Bit 4 flips detector polarity, default zero.
// - Bit 5 enables detector up output, default one, with forced-up bit.
// - Bit 6 enables detector down output, default one, with forced bits.
// - Bits 8:7 cycle-slip mode: off, or 6, 14, 24 ns thresholds.
// - Bit 9 forces pump up output on, test only, default zero.
// - Bit 10 forces pump down output on, test only, default zero.
// - Bit 11 forces pump output to mid rail, test only, default zero.
// - Bits 16:15 set pump op-amp bias, default three.
// - Bits 18:17 gate main counter clock below 32, 128, 1023; three all on.
// - Bits 21:20 select divider pulse width, zero shortest, default zero.
module pump_phase_detector_regs (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Register access from the serial engine
  input  wire logic                         reg_wr_en,
  input  wire logic                         reg_rd_en,
  input  wire logic [ppd_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ppd_pkg::DATA_W-1:0]   reg_wdata,
  output logic      [ppd_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              reg_rd_valid,
  // Analog enable status from outside this bank
  input  wire logic                         opamp_enable,
  // Charge pump controls
  output logic      [ppd_pkg::GAIN_W-1:0]   pump_lower_gain,
  output logic      [ppd_pkg::GAIN_W-1:0]   pump_raise_gain,
  output logic      [ppd_pkg::GAIN_W-1:0]   pump_offset_mag,
  output logic      [ppd_pkg::GAIN_W-1:0]   pump_raise_offset,
  output logic      [ppd_pkg::GAIN_W-1:0]   pump_lower_offset,
  output logic                              high_gain_pump_mode,
  output logic                              high_gain_blocked,
  // Trigger word
  output logic      [ppd_pkg::DATA_W-1:0]   auxiliary_serial_trigger,
  output logic                              trigger_programmed,
  // Phase detector controls
  output logic      [ppd_pkg::DLY_W-1:0]    detector_reset_delay_sel,
  output logic                              detector_input_tie,
  output logic                              phase_polarity_flip,
  output logic                              detector_raise_out_en,
  output logic                              detector_lower_out_en,
  output logic                              pump_raise_path_on,
  output logic                              pump_lower_path_on,
  output logic      [ppd_pkg::F2_W-1:0]     cycle_slip_guard_mode,
  output logic      [4:0]                   cycle_slip_threshold_ns,
  output logic                              force_pump_raise,
  output logic                              force_pump_lower,
  output logic                              force_pump_midrail,
  output logic      [ppd_pkg::PSB_W-1:0]    prescaler_bias,
  output logic      [ppd_pkg::F2_W-1:0]     opamp_bias,
  output logic      [ppd_pkg::F2_W-1:0]     main_counter_clock_gating,
  output logic      [10:0]                  main_counter_gate_limit,
  output logic      [ppd_pkg::F2_W-1:0]     divider_pulse_width
);
  import ppd_pkg::*;

  // Address decode
  wire logic        sel_pump = (reg_addr == ADDR_PUMP);
  wire logic        sel_trig = (reg_addr == ADDR_TRIG);
  wire logic        sel_pd   = (reg_addr == ADDR_PD);
  wire logic        wr_pump  = reg_wr_en & sel_pump;
  wire logic        wr_trig  = reg_wr_en & sel_trig;
  wire logic        wr_pd    = reg_wr_en & sel_pd;
  logic [23:0]      pump_q;
  logic [23:0]      trig_q;
  logic [23:0]      pd_q;

  // Three storage words; writes land whole, spare bits included
  ppd_reg24 #(.W(DATA_W), .RST(PUMP_RST)) u_pump (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (wr_pump),
    .wdata   (reg_wdata),
    .q       (pump_q)
  );
  ppd_reg24 #(.W(DATA_W), .RST(TRIG_RST)) u_trig (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (wr_trig),
    .wdata   (reg_wdata),
    .q       (trig_q)
  );
  ppd_reg24 #(.W(DATA_W), .RST(PD_RST)) u_pd (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (wr_pd),
    .wdata   (reg_wdata),
    .q       (pd_q)
  );

  // Readback mux; unmapped addresses read zero
  wire logic [23:0] rd_mux = sel_pump ? pump_q :
                             sel_trig ? trig_q :
                             sel_pd   ? pd_q   : RD_ZERO;

  logic [23:0] rdata_r;
  logic        rd_valid_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r    <= RD_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rdata_r    <= reg_rd_en ? rd_mux : rdata_r;
      rd_valid_r <= reg_rd_en;
    end
  end
  assign reg_rdata    = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  // Plain field taps straight from the storage flip-flops
  assign pump_lower_gain           = pump_q[P_LGAIN_LSB +: GAIN_W];
  assign pump_raise_gain           = pump_q[P_RGAIN_LSB +: GAIN_W];
  assign pump_offset_mag           = pump_q[P_OFS_LSB +: GAIN_W];
  assign high_gain_pump_mode       = pump_q[P_HIGAIN];
  assign auxiliary_serial_trigger  = trig_q;
  assign detector_reset_delay_sel  = pd_q[D_DLY_LSB +: DLY_W];
  assign detector_input_tie        = pd_q[D_TIE];
  assign phase_polarity_flip       = pd_q[D_FLIP];
  assign detector_raise_out_en     = pd_q[D_RAISE_EN];
  assign detector_lower_out_en     = pd_q[D_LOWER_EN];
  assign cycle_slip_guard_mode     = pd_q[D_CSP_LSB +: F2_W];
  assign force_pump_raise          = pd_q[D_FRC_RAISE];
  assign force_pump_lower          = pd_q[D_FRC_LOWER];
  assign force_pump_midrail        = pd_q[D_FRC_MID];
  assign prescaler_bias            = pd_q[D_PSB_LSB +: PSB_W];
  assign opamp_bias                = pd_q[D_OPB_LSB +: F2_W];
  assign main_counter_clock_gating = pd_q[D_MCG_LSB +: F2_W];
  assign divider_pulse_width       = pd_q[D_DPW_LSB +: F2_W];

  // Directional offsets: a cleared direction bit turns that side off
  wire logic [6:0]  raise_ofs_nxt = pump_q[P_OFS_UP] ? pump_offset_mag : GAIN_ZERO;
  wire logic [6:0]  lower_ofs_nxt = pump_q[P_OFS_DN] ? pump_offset_mag : GAIN_ZERO;

  // High-gain mode cannot work with the op-amp off; flag it for software
  wire logic        hg_block_nxt = high_gain_pump_mode & ~opamp_enable;

  // Software is expected to replace the reset trigger value
  wire logic        trig_ok_nxt = (trig_q == TRIG_PROG);

  // Path enables: mid rail parks both sides, a force overrides the enable
  wire logic        raise_on_nxt = ~force_pump_midrail &
                                   (force_pump_raise | detector_raise_out_en);
  wire logic        lower_on_nxt = ~force_pump_midrail &
                                   (force_pump_lower | detector_lower_out_en);

  // Cycle-slip threshold decode; zero means the guard is off
  wire logic [4:0]  csp_ns_nxt = (cycle_slip_guard_mode == CSP_OFF) ? CSP_NS_OFF :
                                 (cycle_slip_guard_mode == CSP_M1)  ? CSP_NS_1   :
                                 (cycle_slip_guard_mode == CSP_M2)  ? CSP_NS_2   :
                                                                      CSP_NS_3;

  // Counter gating limit decode; code three keeps all clocks running
  wire logic [10:0] mcg_nxt = (main_counter_clock_gating == MCG_C0) ? MCG_LIM_0 :
                              (main_counter_clock_gating == MCG_C1) ? MCG_LIM_1 :
                              (main_counter_clock_gating == MCG_C2) ? MCG_LIM_2 :
                                                                      MCG_LIM_ON;

  // Derived outputs are registered, so they trail a write by two cycles
  logic [6:0]  raise_ofs_r;
  logic [6:0]  lower_ofs_r;
  logic        hg_block_r;
  logic        trig_ok_r;
  logic        raise_on_r;
  logic        lower_on_r;
  logic [4:0]  csp_ns_r;
  logic [10:0] mcg_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      raise_ofs_r <= GAIN_ZERO;
      lower_ofs_r <= GAIN_ZERO;
      hg_block_r  <= 1'b0;
      trig_ok_r   <= 1'b0;
      raise_on_r  <= 1'b0;
      lower_on_r  <= 1'b0;
      csp_ns_r    <= CSP_NS_OFF;
      mcg_r       <= MCG_LIM_ON;
    end else begin
      raise_ofs_r <= raise_ofs_nxt;
      lower_ofs_r <= lower_ofs_nxt;
      hg_block_r  <= hg_block_nxt;
      trig_ok_r   <= trig_ok_nxt;
      raise_on_r  <= raise_on_nxt;
      lower_on_r  <= lower_on_nxt;
      csp_ns_r    <= csp_ns_nxt;
      mcg_r       <= mcg_nxt;
    end
  end
  assign pump_raise_offset       = raise_ofs_r;
  assign pump_lower_offset       = lower_ofs_r;
  assign high_gain_blocked       = hg_block_r;
  assign trigger_programmed      = trig_ok_r;
  assign pump_raise_path_on      = raise_on_r;
  assign pump_lower_path_on      = lower_on_r;
  assign cycle_slip_threshold_ns = csp_ns_r;
  assign main_counter_gate_limit = mcg_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pump_wr;
    wr_pump ##1 1'b1;
  endsequence
  sequence s_pd_wr;
    wr_pd ##1 1'b1;
  endsequence

  a_lower_gain_def: assert property ($rose(reset_n) |-> pump_lower_gain == 7'h0A)
    else $error("down gain default wrong");
  a_lower_gain_wr: assert property (wr_pump |=> pump_lower_gain == $past(reg_wdata[6:0]))
    else $error("down gain not stored");
  a_raise_gain_wr: assert property (wr_pump |=> pump_raise_gain == $past(reg_wdata[13:7]))
    else $error("up gain not stored");
  a_offset_mag_wr: assert property (s_pump_wr |->
      pump_offset_mag == $past(reg_wdata[20:14]))
    else $error("offset magnitude not stored");
  a_raise_offset_dir: assert property (s_pump_wr ##1 !wr_pump |->
      pump_raise_offset == ($past(reg_wdata[21], 2) ? $past(reg_wdata[20:14], 2) : 7'h00))
    else $error("up offset direction wrong");
  a_lower_offset_dir: assert property (s_pump_wr ##1 !wr_pump |->
      pump_lower_offset == ($past(reg_wdata[22], 2) ? $past(reg_wdata[20:14], 2) : 7'h00))
    else $error("down offset direction wrong");
  a_lower_dir_def: assert property ($rose(reset_n) |-> pump_q[22] && !pump_q[21])
    else $error("offset direction defaults wrong");
  a_high_gain_flag: assert property (high_gain_pump_mode && !opamp_enable |=>
      high_gain_blocked)
    else $error("high gain without op-amp not flagged");
  a_trigger_reset: assert property ($rose(reset_n) |-> trig_q == 24'h002205)
    else $error("trigger word default wrong");
  a_delay_sel_def: assert property ($rose(reset_n) |->
      detector_reset_delay_sel == 3'h1 && !detector_input_tie && !phase_polarity_flip)
    else $error("delay or test defaults wrong");
  a_input_tie_wr: assert property (wr_pd |=> detector_input_tie == $past(reg_wdata[3]))
    else $error("input tie not stored");
  a_polarity_wr: assert property (wr_pd |=> phase_polarity_flip == $past(reg_wdata[4]))
    else $error("polarity not stored");
  a_raise_path: assert property (s_pd_wr ##1 !wr_pd |-> pump_raise_path_on ==
      (!$past(reg_wdata[11], 2) && ($past(reg_wdata[9], 2) || $past(reg_wdata[5], 2))))
    else $error("up path enable wrong");
  a_lower_path: assert property (s_pd_wr ##1 !wr_pd |-> pump_lower_path_on ==
      (!$past(reg_wdata[11], 2) && ($past(reg_wdata[10], 2) || $past(reg_wdata[6], 2))))
    else $error("down path enable wrong");
  a_csp_thresh: assert property (cycle_slip_guard_mode == 2'h2 |=>
      cycle_slip_threshold_ns == 5'h0E)
    else $error("cycle slip threshold wrong");
  a_force_raise: assert property (force_pump_raise && !force_pump_midrail |=>
      pump_raise_path_on)
    else $error("forced up not applied");
  a_force_lower: assert property (force_pump_lower && !force_pump_midrail |=>
      pump_lower_path_on)
    else $error("forced down not applied");
  a_midrail_park: assert property (force_pump_midrail |=>
      !pump_raise_path_on && !pump_lower_path_on)
    else $error("mid rail did not park outputs");
  a_opamp_bias_def: assert property ($rose(reset_n) |-> opamp_bias == 2'h3)
    else $error("op-amp bias default wrong");
  a_gating_limit: assert property (main_counter_clock_gating == 2'h1 |=>
      main_counter_gate_limit == 11'h080)
    else $error("counter gating limit wrong");
  a_pulse_width_wr: assert property (wr_pd |=>
      divider_pulse_width == $past(reg_wdata[21:20]))
    else $error("pulse width not stored");
  a_readback_word: assert property (reg_rd_en && sel_pd && !reg_wr_en |=>
      reg_rd_valid && reg_rdata == pd_q)
    else $error("readback mismatch");

  // Every slip and gating code decoded; each output trails its field by one cycle
  a_csp_off: assert property (cycle_slip_guard_mode == 2'h0 |=>
      cycle_slip_threshold_ns == 5'h00)
    else $error("slip guard not off");
  a_csp_low: assert property (cycle_slip_guard_mode == 2'h1 |=>
      cycle_slip_threshold_ns == 5'h06)
    else $error("slip threshold 1 wrong");
  a_csp_wide: assert property (cycle_slip_guard_mode == 2'h3 |=>
      cycle_slip_threshold_ns == 5'h18)
    else $error("slip threshold 3 wrong");
  a_gating_code0: assert property (main_counter_clock_gating == 2'h0 |=>
      main_counter_gate_limit == 11'h020)
    else $error("gating code 0 wrong");
  a_gating_code2: assert property (main_counter_clock_gating == 2'h2 |=>
      main_counter_gate_limit == 11'h3FF)
    else $error("gating code 2 wrong");
  a_gating_all_on: assert property (main_counter_clock_gating == 2'h3 |=>
      main_counter_gate_limit == 11'h000)
    else $error("gating code 3 wrong");

  // Field writes land whole; the taps follow one cycle after the strobe
  a_delay_sel_wr: assert property (wr_pd |=>
      detector_reset_delay_sel == $past(reg_wdata[2:0]))
    else $error("delay select not stored");
  a_enables_wr: assert property (wr_pd |=>
      {detector_lower_out_en, detector_raise_out_en} == $past(reg_wdata[6:5]))
    else $error("output enables not stored");
  a_slip_mode_wr: assert property (wr_pd |=>
      cycle_slip_guard_mode == $past(reg_wdata[8:7]))
    else $error("slip mode not stored");
  a_forces_wr: assert property (wr_pd |=>
      {force_pump_midrail, force_pump_lower, force_pump_raise} == $past(reg_wdata[11:9]))
    else $error("force bits not stored");
  a_gating_wr: assert property (wr_pd |=>
      main_counter_clock_gating == $past(reg_wdata[18:17]))
    else $error("gating code not stored");
  a_high_gain_wr: assert property (wr_pump |=>
      high_gain_pump_mode == $past(reg_wdata[23]))
    else $error("high gain bit not stored");
  a_trigger_wr: assert property (wr_trig |=>
      auxiliary_serial_trigger == $past(reg_wdata))
    else $error("trigger word not stored");

  // Defaults that every reset, first or mid-run, must restore
  a_raise_gain_def: assert property ($rose(reset_n) |->
      pump_raise_gain == 7'h0A)
    else $error("up gain default wrong");
  a_enables_def: assert property ($rose(reset_n) |->
      detector_raise_out_en && detector_lower_out_en)
    else $error("output enable defaults wrong");
  a_gating_def: assert property ($rose(reset_n) |->
      main_counter_clock_gating == 2'h3)
    else $error("gating default wrong");
  a_pulse_width_def: assert property ($rose(reset_n) |->
      divider_pulse_width == 2'h0)
    else $error("pulse width default wrong");

  // Status flags must clear as well as set, or software acts on stale state
  a_high_gain_clear: assert property (!high_gain_pump_mode || opamp_enable |=>
      !high_gain_blocked)
    else $error("high gain flag stuck");
  a_trigger_idle: assert property (trig_q != 24'h001800 |=>
      !trigger_programmed)
    else $error("trigger flag stuck");

  // Read port: valid is a one-cycle pulse, holes in the map read as zero
  a_rd_valid_pulse: assert property (!reg_rd_en |=>
      !reg_rd_valid)
    else $error("read valid without read");
  a_unmapped_read: assert property (reg_rd_en && !sel_pump && !sel_trig && !sel_pd |=>
      reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
endmodule // pump_phase_detector_regs

// *** tb/pump_phase_detector_regs_tb.sv ***
`timescale 1ns/10ps
// Bench for the pump and phase detector register bank, parallel port behind the serial engine
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module pump_phase_detector_regs_tb;
  import ppd_pkg::*;
  // One table row: word written to the detector register and derived outputs it should give
  typedef struct packed {
    logic [23:0] d;
    logic [4:0]  thr;
    logic [10:0] lim;
    logic        rp;
    logic        lp;
  } ppd_row_t;
  localparam int CYCLE_LIMIT = 3000;
  logic                clk          = 1'b0;
  logic                reset_n      = 1'b0;
  logic                reg_wr_en    = 1'b0;
  logic                reg_rd_en    = 1'b0;
  logic [ADDR_W-1:0]   reg_addr     = 6'h00;
  logic [DATA_W-1:0]   reg_wdata    = 24'h000000;
  logic                opamp_enable = 1'b1;
  logic [DATA_W-1:0]   reg_rdata, auxiliary_serial_trigger;
  logic                reg_rd_valid, high_gain_pump_mode, high_gain_blocked, trigger_programmed;
  logic [GAIN_W-1:0]   pump_lower_gain, pump_raise_gain, pump_offset_mag;
  logic [GAIN_W-1:0]   pump_raise_offset, pump_lower_offset;
  logic [DLY_W-1:0]    detector_reset_delay_sel;
  logic                detector_input_tie, phase_polarity_flip;
  logic                detector_raise_out_en, detector_lower_out_en;
  logic                pump_raise_path_on, pump_lower_path_on;
  logic                force_pump_raise, force_pump_lower, force_pump_midrail;
  logic [F2_W-1:0]     cycle_slip_guard_mode, opamp_bias, main_counter_clock_gating;
  logic [F2_W-1:0]     divider_pulse_width;
  logic [4:0]          cycle_slip_threshold_ns;
  logic [PSB_W-1:0]    prescaler_bias;
  logic [10:0]         main_counter_gate_limit;
  int                  fail_count = 0;
  int                  checked    = 0;
  int                  cycles     = 0;
  ppd_row_t            rows [5];

  pump_phase_detector_regs u_dut (
    .clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .opamp_enable(opamp_enable),
    .pump_lower_gain(pump_lower_gain), .pump_raise_gain(pump_raise_gain),
    .pump_offset_mag(pump_offset_mag), .pump_raise_offset(pump_raise_offset),
    .pump_lower_offset(pump_lower_offset), .high_gain_pump_mode(high_gain_pump_mode),
    .high_gain_blocked(high_gain_blocked), .auxiliary_serial_trigger(auxiliary_serial_trigger),
    .trigger_programmed(trigger_programmed), .detector_reset_delay_sel(detector_reset_delay_sel),
    .detector_input_tie(detector_input_tie), .phase_polarity_flip(phase_polarity_flip),
    .detector_raise_out_en(detector_raise_out_en), .detector_lower_out_en(detector_lower_out_en),
    .pump_raise_path_on(pump_raise_path_on), .pump_lower_path_on(pump_lower_path_on),
    .cycle_slip_guard_mode(cycle_slip_guard_mode),
    .cycle_slip_threshold_ns(cycle_slip_threshold_ns), .force_pump_raise(force_pump_raise),
    .force_pump_lower(force_pump_lower), .force_pump_midrail(force_pump_midrail),
    .prescaler_bias(prescaler_bias), .opamp_bias(opamp_bias),
    .main_counter_clock_gating(main_counter_clock_gating),
    .main_counter_gate_limit(main_counter_gate_limit), .divider_pulse_width(divider_pulse_width)
  );

  // Free-running clock, 10 ns period
  always #5 clk = ~clk;

  // Hang guard: a stuck run is cut short and counted as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One-cycle write strobe; returns at the falling edge where the field taps are settled
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  // One-cycle read strobe; valid and data are due exactly one edge later
  task automatic rd(input logic [5:0] a, input logic [23:0] ex);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    `CHK("read valid", 1'b1, reg_rd_valid)
    `CHK("read data", ex, reg_rdata)
  endtask

  initial begin
    // Rows walk every slip mode and gating code, and the force, enable and midrail mixes
    rows[0] = '{24'h000000, 5'h00, 11'h020, 1'b0, 1'b0};
    rows[1] = '{24'h0200A0, 5'h06, 11'h080, 1'b1, 1'b0}; // Low comparison rate assumed
    rows[2] = '{24'h040340, 5'h0E, 11'h3FF, 1'b1, 1'b1};
    rows[3] = '{24'h060DE0, 5'h18, 11'h000, 1'b0, 1'b0};
    rows[4] = '{24'hF9541F, 5'h00, 11'h020, 1'b0, 1'b1};
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    // Defaults straight out of reset
    `CHK("lower gain", 7'h0A, pump_lower_gain)
    `CHK("raise gain", 7'h0A, pump_raise_gain)
    `CHK("offset", 7'h00, pump_offset_mag)
    `CHK("paths", 2'h3, {pump_raise_path_on, pump_lower_path_on})
    `CHK("gate limit", 11'h000, main_counter_gate_limit)
    `CHK("opamp bias", 2'h3, opamp_bias)
    `CHK("trigger done", 1'b0, trigger_programmed)
    rd(ADDR_PUMP, 24'h40050A);
    rd(ADDR_TRIG, 24'h002205);
    rd(ADDR_PD, 24'h0F8061);
    // Table of detector register words
    foreach (rows[i]) begin
      wr(ADDR_PD, rows[i].d);
      `CHK("delay", rows[i].d[2:0], detector_reset_delay_sel)
      `CHK("tie", rows[i].d[3], detector_input_tie)
      `CHK("flip", rows[i].d[4], phase_polarity_flip)
      `CHK("enables", rows[i].d[6:5], {detector_lower_out_en, detector_raise_out_en})
      `CHK("slip mode", rows[i].d[8:7], cycle_slip_guard_mode)
      `CHK("force up", rows[i].d[9], force_pump_raise)
      `CHK("force down", rows[i].d[10], force_pump_lower)
      `CHK("force mid", rows[i].d[11], force_pump_midrail)
      `CHK("prescaler_bias", rows[i].d[14:12], prescaler_bias)
      `CHK("opamp bias", rows[i].d[16:15], opamp_bias)
      `CHK("gating", rows[i].d[18:17], main_counter_clock_gating)
      `CHK("pulse width", rows[i].d[21:20], divider_pulse_width)
      @(negedge clk);
      `CHK("threshold", rows[i].thr, cycle_slip_threshold_ns)
      `CHK("gate limit", rows[i].lim, main_counter_gate_limit)
      `CHK("raise path", rows[i].rp, pump_raise_path_on)
      `CHK("lower path", rows[i].lp, pump_lower_path_on)
      rd(ADDR_PD, rows[i].d);
    end
    // Pump word with full down gain, up gain 0x33, offset upward only
    wr(ADDR_PUMP, 24'h3559FF);
    `CHK("lower gain", 7'h7F, pump_lower_gain)
    `CHK("raise gain", 7'h33, pump_raise_gain)
    `CHK("offset", 7'h55, pump_offset_mag)
    @(negedge clk);
    `CHK("up offset", 7'h55, pump_raise_offset)
    `CHK("down offset", 7'h00, pump_lower_offset)
    // Both directions plus high-gain mode while the op-amp is off
    opamp_enable = 1'b0;
    wr(ADDR_PUMP, 24'hF54000);
    `CHK("high gain", 1'b1, high_gain_pump_mode)
    @(negedge clk);
    `CHK("up offset", 7'h55, pump_raise_offset)
    `CHK("down offset", 7'h55, pump_lower_offset)
    `CHK("blocked", 1'b1, high_gain_blocked)
    opamp_enable = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("blocked", 1'b0, high_gain_blocked)
    // Trigger word rewritten with its working value
    wr(ADDR_TRIG, 24'h001800);
    `CHK("trigger word", 24'h001800, auxiliary_serial_trigger)
    @(negedge clk);
    `CHK("trigger done", 1'b1, trigger_programmed)
    // Unmapped address: write dropped, read answers zero with valid
    wr(6'h0C, 24'hFFFFFF);
    rd(6'h0C, 24'h000000);
    rd(ADDR_PUMP, 24'hF54000);
    // Write and read of one address in one cycle: read sees the old word
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_rd_en = 1'b1;
    reg_addr  = ADDR_TRIG;
    reg_wdata = 24'hABCDEF;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    `CHK("old word", 24'h001800, reg_rdata)
    rd(ADDR_TRIG, 24'hABCDEF);
    // Second reset in mid-run restores every default
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    rd(ADDR_PUMP, 24'h40050A);
    rd(ADDR_TRIG, 24'h002205);
    rd(ADDR_PD, 24'h0F8061);
    @(negedge clk);
    `CHK("valid drop", 1'b0, reg_rd_valid)
    tally_and_finish();
  end
endmodule // pump_phase_detector_regs_tb
